// ===== hw/rdc_pkg.sv
// rdc_pkg: constants, register map and helpers of the rtc divider chain
// assumes a 32-bit axi4-lite register bus and one oscillator clock
package rdc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // divider chain
   localparam int unsigned OSC_DIV = 32;
   localparam int unsigned PRE_DIV = 8;
   localparam int unsigned TMR_W   = 16;
   localparam int unsigned CNT_W   = 32;
   localparam int unsigned AXI_AW  = 18;

   ////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam logic [15:0] ICTRL_IDX  = 16'hf19e;
   localparam logic [17:0] OFF_ICTRL  = {ICTRL_IDX, 2'b00};
   localparam logic [17:0] OFF_RELOAD = 18'h0_0000;
   localparam logic [17:0] OFF_TMR    = 18'h0_0004;
   localparam logic [17:0] OFF_CLO    = 18'h0_0008;
   localparam logic [17:0] OFF_CHI    = 18'h0_000c;
   localparam logic [17:0] OFF_STAT   = 18'h0_0010;
   localparam logic [17:0] OFF_CLR    = 18'h0_0014;
   localparam logic [17:0] OFF_EN     = 18'h0_0018;

   // fields
   localparam int unsigned IC_REQ_BIT = 7;
   localparam int unsigned IC_EN_BIT  = 6;
   localparam int unsigned IC_LVL_W   = 6;
   localparam int unsigned ST_PRE     = 0;
   localparam int unsigned ST_WRAP    = 1;
   localparam int unsigned ST_W       = 2;

   // reset values
   localparam logic [15:0]     ICTRL_RST = 16'h0000;
   localparam logic [ST_W-1:0] IRQ_RST   = 2'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      R_RELOAD, R_TMR, R_CLO, R_CHI, R_STAT, R_CLR, R_EN, R_ICTRL, R_NONE
   } rdc_reg_t;

   function automatic rdc_reg_t rdc_decode(input logic [AXI_AW-1:0] a);
      unique case (a)
         OFF_RELOAD: return R_RELOAD;
         OFF_TMR:    return R_TMR;
         OFF_CLO:    return R_CLO;
         OFF_CHI:    return R_CHI;
         OFF_STAT:   return R_STAT;
         OFF_CLR:    return R_CLR;
         OFF_EN:     return R_EN;
         OFF_ICTRL:  return R_ICTRL;
         default:    return R_NONE;
      endcase
   endfunction : rdc_decode

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] rdc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : rdc_merge

endpackage : rdc_pkg

// ===== hw/rdc_div.sv
// rdc_div: oscillator /32 then fixed /8 prescaler, one-cycle tick out
// assumes clk is the oscillator itself, not the cpu clock
`timescale 1ns/1ps
module rdc_div #(
   parameter int unsigned OSC_DIV = rdc_pkg::OSC_DIV,
   parameter int unsigned PRE_DIV = rdc_pkg::PRE_DIV
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // tick after both fixed stages
   output logic      pre_tick
);
   import rdc_pkg::*;

   // both counters are 8 bits wide
   if (OSC_DIV < 2 || OSC_DIV > 256 || PRE_DIV < 1 || PRE_DIV > 256) begin : g_bad_div
      $error("rdc_div: divider out of range");
   end

   logic [7:0] osc_q, osc_d;
   logic [7:0] pre_q, pre_d;
   logic       tick_q, tick_d;
   logic       rtc_en;

   ////////////////////////////////////////////////////////////////////////
   // only the oscillator feeds this chain, so cpu clock mode never matters
   always_comb begin
      rtc_en = (osc_q == 8'(OSC_DIV - 1));
      osc_d  = rtc_en ? 8'h00 : osc_q + 8'h01;
      pre_d  = pre_q;
      tick_d = 1'b0;
      if (rtc_en) begin
         tick_d = (pre_q == 8'(PRE_DIV - 1));
         pre_d  = tick_d ? 8'h00 : pre_q + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_q  <= 8'h00;
         pre_q  <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         osc_q  <= osc_d;
         pre_q  <= pre_d;
         tick_q <= tick_d;
      end
   end

   assign pre_tick = tick_q;

endmodule : rdc_div

// ===== hw/rdc_axil.sv
// rdc_axil: axi4-lite slave front end, one write and one read at a time
// assumes the owner decodes addresses and reports mapped/unmapped
`timescale 1ns/1ps
module rdc_axil (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // axi4-lite
   input  wire logic [rdc_pkg::AXI_AW-1:0] awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   // register side
   output logic                           wr_go,
   output logic [rdc_pkg::AXI_AW-1:0]     wr_addr,
   output logic [31:0]                    wr_data,
   output logic [3:0]                     wr_strb,
   input  wire logic                      wr_ok,
   input  wire logic [31:0]               rd_data,
   input  wire logic                      rd_ok
);
   import rdc_pkg::*;

   logic              awf_q, awf_d, wf_q, wf_d;
   logic [AXI_AW-1:0] addr_q, addr_d;
   logic [31:0]       data_q, data_d, rdata_q, rdata_d;
   logic [3:0]        strb_q, strb_d;
   logic              bv_q, bv_d, rv_q, rv_d;
   logic [1:0]        br_q, br_d, rr_q, rr_d;
   logic              awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
   logic              aw_take, w_take, ar_take, go;

   ////////////////////////////////////////////////////////////////////////
   // address and data are held separately so they may arrive in any order
   always_comb begin
      aw_take = awvalid && awr_q;
      w_take  = wvalid && wr_q;
      ar_take = arvalid && arr_q;
      go      = awf_q && wf_q && !bv_q;
      awf_d   = go ? 1'b0 : (awf_q || aw_take);
      wf_d    = go ? 1'b0 : (wf_q || w_take);
      addr_d  = aw_take ? awaddr : addr_q;
      data_d  = w_take ? wdata : data_q;
      strb_d  = w_take ? wstrb : strb_q;
      bv_d    = go || (bv_q && !bready);
      br_d    = go ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : br_q;
      awr_d   = !awf_d && !bv_d;
      wr_d    = !wf_d && !bv_d;
      rv_d    = ar_take || (rv_q && !rready);
      rdata_d = ar_take ? rd_data : rdata_q;
      rr_d    = ar_take ? (rd_ok ? RESP_OKAY : RESP_SLVERR) : rr_q;
      arr_d   = !rv_d;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awf_q <= 1'b0; wf_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
         addr_q <= '0; data_q <= 32'h0000_0000; strb_q <= 4'h0;
         br_q <= RESP_OKAY; rr_q <= RESP_OKAY; rdata_q <= 32'h0000_0000;
         awr_q <= 1'b0; wr_q <= 1'b0; arr_q <= 1'b0;
      end else begin
         awf_q <= awf_d; wf_q <= wf_d; bv_q <= bv_d; rv_q <= rv_d;
         addr_q <= addr_d; data_q <= data_d; strb_q <= strb_d;
         br_q <= br_d; rr_q <= rr_d; rdata_q <= rdata_d;
         awr_q <= awr_d; wr_q <= wr_d; arr_q <= arr_d;
      end
   end

   assign awready = awr_q;
   assign wready  = wr_q;
   assign arready = arr_q;
   assign bvalid  = bv_q;
   assign bresp   = br_q;
   assign rvalid  = rv_q;
   assign rresp   = rr_q;
   assign rdata   = rdata_q;
   assign wr_go   = go;
   assign wr_addr = addr_q;
   assign wr_data = data_q;
   assign wr_strb = strb_q;

endmodule : rdc_axil

// ===== hw/rdc_top.sv
// rdc_top: rtc divider chain (fixed /8, reloadable 16-bit, 32-bit count)
// assumes clk is the 20 MHz oscillator and software uses axi4-lite
//
// Operation
// - the chain is clocked from the oscillator divided by 32 by its own divider.
// - cpu clock generation mode has no path into the chain or its rate.
// - three stages in series: fixed /8, reloadable prescale timer, long count.
// - the middle stage is a 16-bit timer that restarts from a reload value.
// - the 32-bit long count is read and written as low and high halves.
// - every stage counts upward.
// - reload, prescale timer and long count keep their value through reset.
// - a periodic interrupt is raised from the time base.
// - prescale timer overflow carries into the long count; only with reload zero do they form one 48-bit counter.
// - the interrupt control register shared with the pll resets to zero.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module rdc_top (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // axi4-lite write
   input  wire logic [rdc_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // axi4-lite read
   input  wire logic [rdc_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // interrupt
   output logic                            irq
);
   import rdc_pkg::*;

   logic              pre_tick;
   logic              wr_go, wr_ok, rd_ok;
   logic [AXI_AW-1:0] wr_addr;
   logic [31:0]       wr_data, rd_data;
   logic [3:0]        wr_strb;
   rdc_reg_t          wsel, rsel;

   ////////////////////////////////////////////////////////////////////////
   // fixed stages and bus front end

   rdc_div #(
      .OSC_DIV (OSC_DIV),
      .PRE_DIV (PRE_DIV)
   ) rdc_div_i (
      .clk      (clk),
      .rst      (rst),
      .pre_tick (pre_tick)
   );

   rdc_axil rdc_axil_i (
      .clk     (clk),
      .rst     (rst),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_go   (wr_go),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   ////////////////////////////////////////////////////////////////////////
   // time base state: no reset, so system time survives any reset

   // the 32-bit long count lives in two halves, so the chain is 48 bits
   localparam int unsigned HALF_W = CNT_W / 2;

   logic [TMR_W-1:0]  reload_q, reload_d, tmr_q, tmr_d;
   logic [HALF_W-1:0] clo_q, clo_d, chi_q, chi_d;
   logic [CNT_W-1:0]  cnt_inc;
   logic              ovf, wrap;
   logic              wr_rel, wr_tmr, wr_clo, wr_chi;

   always_comb begin
      wsel    = rdc_decode(wr_addr);
      wr_rel  = wr_go && (wsel == R_RELOAD);
      wr_tmr  = wr_go && (wsel == R_TMR);
      wr_clo  = wr_go && (wsel == R_CLO);
      wr_chi  = wr_go && (wsel == R_CHI);
      ovf     = pre_tick && (tmr_q == '1);
      wrap    = ovf && ({chi_q, clo_q} == '1);
      cnt_inc = {chi_q, clo_q} + 32'h0000_0001;
      reload_d = wr_rel ? 16'(rdc_merge({16'h0000, reload_q}, wr_data, wr_strb))
                        : reload_q;
      tmr_d = tmr_q;
      if (wr_tmr) begin
         tmr_d = 16'(rdc_merge({16'h0000, tmr_q}, wr_data, wr_strb));
      end else if (ovf) begin
         tmr_d = reload_q;
      end else if (pre_tick) begin
         tmr_d = tmr_q + 16'h0001;
      end
      // a written half wins; the other half still takes its carry
      clo_d = wr_clo ? 16'(rdc_merge({16'h0000, clo_q}, wr_data, wr_strb))
                     : (ovf ? cnt_inc[HALF_W-1:0] : clo_q);
      chi_d = wr_chi ? 16'(rdc_merge({16'h0000, chi_q}, wr_data, wr_strb))
                     : (ovf ? cnt_inc[CNT_W-1:HALF_W] : chi_q);
   end

   always_ff @(posedge clk) begin
      reload_q <= reload_d;
      tmr_q    <= tmr_d;
      clo_q    <= clo_d;
      chi_q    <= chi_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt control; request and enable of the shared control register
   // are the same flops as status bit 0 and enable bit 0

   logic [ST_W-1:0]     stat_q, stat_d, en_q, en_d, clr;
   logic [IC_LVL_W-1:0] lvl_q, lvl_d;
   logic                irq_q, irq_d;
   logic [31:0]         icw;

   always_comb begin
      icw    = rdc_merge({16'h0000, ictrl_rd()}, wr_data, wr_strb);
      clr    = (wr_go && wsel == R_CLR) ? wr_data[ST_W-1:0] : '0;
      stat_d = stat_q & ~clr;
      en_d   = (wr_go && wsel == R_EN) ? wr_data[ST_W-1:0] : en_q;
      lvl_d  = lvl_q;
      if (wr_go && wsel == R_ICTRL) begin
         stat_d[ST_PRE] = icw[IC_REQ_BIT];
         en_d[ST_PRE]   = icw[IC_EN_BIT];
         lvl_d          = icw[IC_LVL_W-1:0];
      end
      // an event in the clearing cycle is kept
      if (ovf) begin
         stat_d[ST_PRE] = 1'b1;
      end
      if (wrap) begin
         stat_d[ST_WRAP] = 1'b1;
      end
      irq_d = |(stat_d & en_d);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= IRQ_RST;
         en_q   <= IRQ_RST;
         lvl_q  <= ICTRL_RST[IC_LVL_W-1:0];
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         en_q   <= en_d;
         lvl_q  <= lvl_d;
         irq_q  <= irq_d;
      end
   end

   assign irq = irq_q;

   function automatic logic [15:0] ictrl_rd();
      logic [15:0] v;
      v                = ICTRL_RST;
      v[IC_REQ_BIT]    = stat_q[ST_PRE];
      v[IC_EN_BIT]     = en_q[ST_PRE];
      v[IC_LVL_W-1:0]  = lvl_q;
      return v;
   endfunction : ictrl_rd

   ////////////////////////////////////////////////////////////////////////
   // register read and response decode

   logic [15:0] ictrl_v;

   always_comb begin
      rsel    = rdc_decode(s_axi_araddr);
      ictrl_v = ictrl_rd();
      rd_ok   = (rsel != R_NONE);
      wr_ok   = (wsel != R_NONE);
      rd_data = 32'h0000_0000;
      unique case (rsel)
         R_RELOAD: rd_data = {16'h0000, reload_q};
         R_TMR:    rd_data = {16'h0000, tmr_q};
         R_CLO:    rd_data = {16'h0000, clo_q};
         R_CHI:    rd_data = {16'h0000, chi_q};
         R_STAT:   rd_data = {30'h0, stat_q};
         R_EN:     rd_data = {30'h0, en_q};
         R_ICTRL:  rd_data = {16'h0000, ictrl_v};
         R_CLR:    rd_data = 32'h0000_0000;
         R_NONE:   rd_data = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [8:0] gap_q;
   logic       seen_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q  <= 9'h000;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= pre_tick ? 9'h000 : gap_q + 9'h001;
         seen_q <= seen_q || pre_tick;
      end
   end

   a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
      pre_tick && seen_q |-> gap_q == 9'(OSC_DIV * PRE_DIV - 1))
      else $error("prescale tick spacing wrong");

   a_tick_pulse: assert property (@(posedge clk) disable iff (rst)
      pre_tick |=> !pre_tick)
      else $error("prescale tick longer than one cycle");

   a_tmr_reload: assert property (@(posedge clk) disable iff (rst)
      ovf && !wr_tmr |=> tmr_q == $past(reload_q))
      else $error("prescale timer did not reload");

   a_tmr_up: assert property (@(posedge clk) disable iff (rst)
      pre_tick && !ovf && !wr_tmr |=> tmr_q == $past(tmr_q) + 16'h0001)
      else $error("prescale timer did not count up");

   a_tmr_idle: assert property (@(posedge clk) disable iff (rst)
      !pre_tick && !wr_tmr |=> $stable(tmr_q))
      else $error("prescale timer moved without tick");

   a_tmr_write: assert property (@(posedge clk) disable iff (rst)
      wr_tmr && wr_strb == 4'hf |=> tmr_q == $past(wr_data[TMR_W-1:0]))
      else $error("prescale timer write lost");

   a_reload_write: assert property (@(posedge clk) disable iff (rst)
      wr_rel && wr_strb == 4'hf |=> reload_q == $past(wr_data[TMR_W-1:0]))
      else $error("reload write lost");

   a_count_adv: assert property (@(posedge clk) disable iff (rst)
      ovf && !wr_clo && !wr_chi |=> {chi_q, clo_q} == $past({chi_q, clo_q}) + 32'h0000_0001)
      else $error("long count did not advance");

   a_count_hold: assert property (@(posedge clk) disable iff (rst)
      !ovf && !wr_clo && !wr_chi |=> $stable({chi_q, clo_q}))
      else $error("long count moved without overflow");

   a_wrap_set: assert property (@(posedge clk) disable iff (rst)
      wrap |=> stat_q[ST_WRAP])
      else $error("wrap flag not set");

   a_req_set: assert property (@(posedge clk) disable iff (rst)
      ovf |=> stat_q[ST_PRE] && ictrl_v[IC_REQ_BIT])
      else $error("request flag not set");

   a_req_sticky: assert property (@(posedge clk) disable iff (rst)
      stat_q[ST_PRE] && !(wr_go && (wsel == R_CLR || wsel == R_ICTRL))
      |=> stat_q[ST_PRE])
      else $error("request flag dropped");

   // a clear that meets an overflow in the same cycle must lose
   a_req_race: assert property (@(posedge clk) disable iff (rst)
      ovf && wr_go && (wsel == R_CLR || wsel == R_ICTRL) |=> stat_q[ST_PRE])
      else $error("request flag lost to a clear");

   a_req_clear: assert property (@(posedge clk) disable iff (rst)
      wr_go && wsel == R_CLR && wr_data[ST_PRE] && !ovf |=> !stat_q[ST_PRE])
      else $error("request flag not cleared");

   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      irq == |(stat_q & en_q))
      else $error("irq does not follow status and enable");

   a_ictrl_reset: assert property (@(posedge clk)
      $fell(rst) |-> ictrl_v == ICTRL_RST)
      else $error("control register not zero after reset");

   c_overflow: cover property (@(posedge clk) disable iff (rst) ovf);
   c_wrap: cover property (@(posedge clk) disable iff (rst) wrap);
   c_irq_rise: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   c_clr_race: cover property (@(posedge clk) disable iff (rst)
      ovf && wr_go && wsel == R_CLR);
   c_ictrl_write: cover property (@(posedge clk) disable iff (rst) wr_go && wsel == R_ICTRL);

endmodule : rdc_top

// ===== dv/rdc_top_tb.sv
// rdc_top_tb: self-checking bench for the rtc divider chain behind axi4-lite
// assumes rdc_top built with package divider values and a 20 MHz clk
`timescale 1ns/1ps
module rdc_top_tb;
   import rdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // clock, reset and bus signals
   logic                clk     = 1'b0;
   logic                rst     = 1'b1;
   logic [AXI_AW-1:0]   awaddr  = '0;
   logic                awvalid = 1'b0;
   logic                awready;
   logic [31:0]         wdata   = '0;
   logic [3:0]          wstrb   = '0;
   logic                wvalid  = 1'b0;
   logic                wready;
   logic [1:0]          bresp;
   logic                bvalid;
   logic                bready  = 1'b0;
   logic [AXI_AW-1:0]   araddr  = '0;
   logic                arvalid = 1'b0;
   logic                arready;
   logic [31:0]         rdata;
   logic [1:0]          rresp;
   logic                rvalid;
   logic                rready  = 1'b0;
   logic                irq;
   int unsigned         cyc      = 0;
   int                  n_errors = 0;
   int                  checks   = 0;

   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   rdc_top rdc_top_i (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers: every bus task is entered just after a rising edge
   task automatic finish_test;
      if (n_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // handshakes are judged at the falling edge, where the registered
   // outputs have settled and equal what the next rising edge samples
   task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic ha, hw, hb;
      logic [1:0] r;
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      hb = 1'b0;
      while (!hb && n < 40) begin
         @(negedge clk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid & bready;
         r = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      chk("write answered", 32'(hb), 32'h0000_0001);
      chk("bresp", 32'(r), 32'(er));
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, input logic [1:0] er);
      int   n;
      logic ha, hr;
      logic [1:0] r;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      hr = 1'b0;
      while (!hr && n < 40) begin
         @(negedge clk);
         ha = arvalid & arready;
         hr = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      chk("read answered", 32'(hr), 32'h0000_0001);
      chk("rresp", 32'(r), 32'(er));
      @(posedge clk);
   endtask : rd

   task automatic rd_chk(input string nm, input logic [AXI_AW-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d, RESP_OKAY);
      chk(nm, d, e);
   endtask : rd_chk

   task automatic irq_is(input logic e);
      @(negedge clk);
      chk("irq", 32'(irq), 32'(e));
      @(posedge clk);
   endtask : irq_is

   // bounded wait; the cycle count of the edge that raised irq is returned
   task automatic wait_irq(output int unsigned t);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== 1'b1 && n < 600);
      t = cyc;
      chk("irq raised", 32'(irq), 32'h0000_0001);
      @(posedge clk);
   endtask : wait_irq

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      rd_chk("ctrl reset", OFF_ICTRL, 32'h0000_0000);
      rd_chk("status reset", OFF_STAT, 32'h0000_0000);
      irq_is(1'b0);
   endtask : t_reset

   task automatic t_regs;
      logic [31:0] d;
      wr(OFF_TMR, 32'h0000_0000, RESP_OKAY);
      wr(OFF_RELOAD, 32'h0000_1234, RESP_OKAY);
      rd_chk("reload", OFF_RELOAD, 32'h0000_1234);
      wr(OFF_CLO, 32'ha5a5_5a5a, RESP_OKAY);
      wr(OFF_CHI, 32'h0000_0001, RESP_OKAY);
      rd_chk("count low", OFF_CLO, 32'h0000_5a5a);
      rd_chk("count high", OFF_CHI, 32'h0000_0001);
      // unmapped place answers with an error both ways
      wr(18'h0_0020, 32'hffff_ffff, RESP_SLVERR);
      rd(18'h0_0020, d, RESP_SLVERR);
      rd_chk("clear reads zero", OFF_CLR, 32'h0000_0000);
      wr(OFF_ICTRL, 32'h0000_0025, RESP_OKAY);
      rd_chk("ctrl level", OFF_ICTRL, 32'h0000_0025);
      wr(OFF_ICTRL, 32'h0000_0000, RESP_OKAY);
   endtask : t_regs

   task automatic t_carry;
      int unsigned t;
      wr(OFF_CLR, 32'h0000_0003, RESP_OKAY);
      wr(OFF_EN, 32'h0000_0001, RESP_OKAY);
      wr(OFF_RELOAD, 32'h0000_fff0, RESP_OKAY);
      wr(OFF_CLO, 32'hffff_ffff, RESP_OKAY);
      wr(OFF_CHI, 32'h0000_0007, RESP_OKAY);
      // timer written last so no overflow can land before the chain is set
      wr(OFF_TMR, 32'h0000_ffff, RESP_OKAY);
      wait_irq(t);
      rd_chk("timer reloaded", OFF_TMR, 32'h0000_fff0);
      rd_chk("carry low", OFF_CLO, 32'h0000_0000);
      rd_chk("carry high", OFF_CHI, 32'h0000_0008);
      rd_chk("status set", OFF_STAT, 32'h0000_0001);
      rd_chk("ctrl request", OFF_ICTRL, 32'h0000_00c0);
      repeat (20) @(posedge clk);
      irq_is(1'b1);
      wr(OFF_EN, 32'h0000_0000, RESP_OKAY);
      irq_is(1'b0);
      rd_chk("status masked", OFF_STAT, 32'h0000_0001);
      wr(OFF_EN, 32'h0000_0001, RESP_OKAY);
      irq_is(1'b1);
      wr(OFF_CLR, 32'h0000_0001, RESP_OKAY);
      irq_is(1'b0);
      rd_chk("status cleared", OFF_STAT, 32'h0000_0000);
   endtask : t_carry

   task automatic t_rate;
      int unsigned t0, t1;
      wr(OFF_RELOAD, 32'h0000_ffff, RESP_OKAY);
      wr(OFF_TMR, 32'h0000_ffff, RESP_OKAY);
      // every tick now overflows, so irq edges mark the tick period
      wait_irq(t0);
      wr(OFF_CLR, 32'h0000_0001, RESP_OKAY);
      wait_irq(t0);
      wr(OFF_CLR, 32'h0000_0001, RESP_OKAY);
      wait_irq(t1);
      chk("tick period", 32'(t1 - t0), 32'(OSC_DIV * PRE_DIV));
      wr(OFF_CLR, 32'h0000_0003, RESP_OKAY);
   endtask : t_rate

   task automatic t_keep;
      wr(OFF_RELOAD, 32'h0000_4321, RESP_OKAY);
      wr(OFF_TMR, 32'h0000_0100, RESP_OKAY);
      wr(OFF_CLO, 32'h1357_2468, RESP_OKAY);
      wr(OFF_CHI, 32'h0000_00ab, RESP_OKAY);
      wr(OFF_ICTRL, 32'h0000_0011, RESP_OKAY);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk("reload kept", OFF_RELOAD, 32'h0000_4321);
      rd_chk("low kept", OFF_CLO, 32'h0000_2468);
      rd_chk("high kept", OFF_CHI, 32'h0000_00ab);
      rd_chk("ctrl cleared", OFF_ICTRL, 32'h0000_0000);
      irq_is(1'b0);
   endtask : t_keep

   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_regs();
      t_carry();
      t_rate();
      t_keep();
      finish_test();
   end

   // the whole run needs under two thousand cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end

endmodule : rdc_top_tb
